// *** dv/hbs_bridge_model.sv ***
// Switch-node model of the three external half-bridges.
`timescale 1ns/10ps
module hbs_bridge_model #(
	parameter integer NB = 3
) (
	// Clock
	input  wire          clk_in,
	// Gate levels
	input  wire [NB-1:0] hs_on_in,
	input  wire [NB-1:0] ls_on_in,
	// Switch nodes
	output reg  [NB-1:0] sw_out
);
	integer b;
	initial sw_out = 0;
	// A node with both switches open floats, so it shows the inverse of its last level.
	always @(posedge clk_in) begin
		for (b = 0; b < NB; b = b + 1) begin
			if (hs_on_in[b])
				sw_out[b] <= 1'b1;
			else if (ls_on_in[b])
				sw_out[b] <= 1'b0;
			else
				sw_out[b] <= ~sw_out[b];
		end
	end
endmodule // hbs_bridge_model

// *** dv/hbs_sequencer_properties.sv ***
// Port assertions of the static gate sequencer.
`timescale 1ns/10ps
module hbs_props (
	input wire        ref_clk_in,
	input wire        reset_in,
	input wire        cs_n_in,
	input wire        charge_pump_enable_in,
	input wire [11:0] static_drive_current_code_in,
	input wire [2:0]  high_side_gate_on_out,
	input wire [2:0]  low_side_gate_on_out,
	input wire [8:0]  high_side_gate_act_out,
	input wire [8:0]  low_side_gate_act_out,
	input wire [17:0] high_side_gate_step_out,
	input wire [17:0] low_side_gate_step_out,
	input wire [2:0]  bridge_busy_out,
	input wire        cmd_exec_out
);
	wire [2:0] ha = high_side_gate_act_out[2:0];
	wire [2:0] la = low_side_gate_act_out[2:0];
	wire [5:0] hs = high_side_gate_step_out[5:0];
	wire [5:0] ls = low_side_gate_step_out[5:0];
	wire [5:0] st = {static_drive_current_code_in[3:0], 2'h0};
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (reset_in);
	sequence s_guard; ha == 3'h2 && la == 3'h2; endsequence
	sequence s_charge; ha == 3'h1 && la == 3'h3; endsequence
	property p_pump_off; !charge_pump_enable_in [*5] |->
		high_side_gate_act_out == 0 && low_side_gate_act_out == 0; endproperty
	property p_no_cross; (high_side_gate_on_out & low_side_gate_on_out) == 0; endproperty
	property p_charge_step; ha == 3'h1 |-> hs == st; endproperty
	property p_guard; s_guard |-> hs == st && ls == st && bridge_busy_out[0]; endproperty
	property p_hard_off; la == 3'h3 |-> s_charge ##0 ls == 6'h3F; endproperty
	property p_hold; ha == 3'h4 |-> la == 3'h5 && (hs == 6'h0F || hs == 6'h14); endproperty
	property p_exec_pulse; cmd_exec_out |=> !cmd_exec_out; endproperty
	property p_exec_lat; $rose(cs_n_in) |-> ##[1:300] cmd_exec_out; endproperty
	a_pump_off: assert property (p_pump_off) else $error("gates driven with pump off");
	a_no_cross: assert property (p_no_cross) else $error("both gates on");
	a_charge_step: assert property (p_charge_step) else $error("charge step");
	a_guard: assert property (p_guard) else $error("guard phase drive");
	a_hard_off: assert property (p_hard_off) else $error("hard-off phase");
	a_hold: assert property (p_hold) else $error("hold phase");
	a_exec_pulse: assert property (p_exec_pulse) else $error("exec pulse width");
	a_exec_lat: assert property (p_exec_lat) else $error("exec latency");
endmodule // hbs_props

bind hbs_sequencer hbs_props u_props (.*);

// *** dv/hbs_sequencer_tb.sv ***
// Self-checking testbench of the static gate sequencer.
`timescale 1ns/10ps
module hbs_sequencer_tb;
	reg         ref_clk = 1'b0;
	reg         rst = 1'b1;
	reg         cs_n = 1'b1;
	reg         cpe = 1'b1;
	reg         hsel = 1'b0;
	reg  [2:0]  psel = 3'h0;
	reg  [2:0]  pwm = 3'h0;
	reg  [5:0]  mode = 6'h00;
	reg  [11:0] code = 12'h000;
	wire [2:0]  hs_on, ls_on, busy, sw;
	wire [8:0]  hs_act, ls_act;
	wire [17:0] hs_st, ls_st;
	wire        ex;
	reg  [24:0] rows [0:3];
	reg  [24:0] r;
	integer     err_count = 0, checks = 0, i, n;

	hbs_sequencer dut (.ref_clk_in(ref_clk), .reset_in(rst), .cs_n_in(cs_n),
		.charge_pump_enable_in(cpe), .bridge_mode_sel_in(mode),
		.bridge_pwm_select_in(psel), .static_drive_current_code_in(code),
		.hold_current_select_in(hsel), .pwm_in(pwm),
		.guard_time_in({3{16'h0004}}), .blank_time_in({3{16'h0003}}),
		.drain_source_filter_time_in({3{16'h0002}}),
		.high_side_gate_on_out(hs_on), .low_side_gate_on_out(ls_on),
		.high_side_gate_act_out(hs_act), .low_side_gate_act_out(ls_act),
		.high_side_gate_step_out(hs_st), .low_side_gate_step_out(ls_st),
		.bridge_busy_out(busy), .cmd_exec_out(ex));
	hbs_bridge_model u_fets (.clk_in(ref_clk), .hs_on_in(hs_on), .ls_on_in(ls_on), .sw_out(sw));

	initial forever #5 ref_clk = ~ref_clk;

	task chk(input [8*8:1] nm, input [17:0] s, input [17:0] e);
		checks = checks + 1;
		if (s !== e) begin
			err_count = err_count + 1;
			$display("ERROR %0s exp %h seen %h", nm, e, s);
		end
	endtask
	task cmd(input [1:0] m, input [3:0] c, input h);
		@(posedge ref_clk);
		mode <= {3{m}};
		code <= {3{c}};
		hsel <= h;
		cs_n <= 1'b0;
		repeat (4) @(posedge ref_clk);
		cs_n <= 1'b1;
	endtask
	task wait_busy(input v);
		n = 0;
		while (busy[0] !== v && n < 200) begin
			@(posedge ref_clk);
			#1;
			n = n + 1;
		end
		if (n >= 200) chk("busy", busy[0], v);
	endtask
	task settle;
		n = 0;
		while (ex !== 1'b1 && n < 300) begin
			@(posedge ref_clk);
			#1;
			n = n + 1;
		end
		chk("exec", ex, 1'b1);
		wait_busy(1'b0);
	endtask
	task test_done;
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	initial begin
		#100000;
		err_count = err_count + 1;
		test_done;
	end

	initial begin
		rows[0] = {2'h3, 4'h5, 1'h0, 3'h5, 3'h5, 6'h0F, 6'h0F};
		rows[1] = {2'h2, 4'h9, 1'h1, 3'h4, 3'h5, 6'h14, 6'h14};
		rows[2] = {2'h1, 4'hF, 1'h0, 3'h5, 3'h4, 6'h0F, 6'h0F};
		rows[3] = {2'h0, 4'h0, 1'h0, 3'h0, 3'h0, 6'h00, 6'h00};
		repeat (20) @(posedge ref_clk);
		rst <= 1'b0;
		for (i = 0; i < 4; i = i + 1) begin
			r = rows[i];
			cmd(r[24:23], r[22:19], r[18]);
			settle;
			chk("hs_act", hs_act, {3{r[17:15]}});
			chk("ls_act", ls_act, {3{r[14:12]}});
			if (r[17:15] != 3'h0) chk("hs_step", hs_st, {3{r[11:6]}});
			if (r[14:12] != 3'h0) chk("ls_step", ls_st, {3{r[5:0]}});
			chk("hs_on", hs_on, {3{r[24:23] == 2'h2}});
			chk("ls_on", ls_on, {3{r[24:23] == 2'h1}});
			if (r[24] ^ r[23]) chk("sw", sw, {3{r[24]}});
			$display("row %0d done", i);
		end
		// The guarded turn-on starts from a low-side that is already on.
		cmd(2'h1, 4'hF, 1'b0);
		settle;
		cmd(2'h2, 4'hF, 1'b0);
		wait_busy(1'b1);
		chk("hs_act", hs_act, {3{3'h2}});
		chk("ls_st", ls_st, {3{6'h3C}});
		n = 0;
		while (hs_act[2:0] !== 3'h1 && n < 50) begin
			@(posedge ref_clk);
			#1;
			n = n + 1;
		end
		chk("guard", n[17:0], 18'h4);
		chk("ls_act", ls_act, {3{3'h3}});
		chk("ls_st", ls_st, {3{6'h3F}});
		wait_busy(1'b0);
		chk("hs_act", hs_act, {3{3'h4}});
		cmd(2'h3, 4'h2, 1'b0);
		wait_busy(1'b1);
		chk("off_act", {hs_act, ls_act}, {6{3'h2}});
		settle;
		cmd(2'h2, 4'h3, 1'b1);
		wait_busy(1'b1);
		chk("hs_act", hs_act, {3{3'h1}});
		settle;
		$display("sequence tests done");
		@(posedge ref_clk);
		psel <= 3'h7;
		cmd(2'h2, 4'h3, 1'b1);
		settle;
		chk("pwm_lo", hs_on, 3'h0);
		@(posedge ref_clk);
		pwm <= 3'h7;
		repeat (4) @(posedge ref_clk);
		#1;
		chk("pwm_hi", hs_on, 3'h7);
		chk("pwm_ls", ls_on, 3'h0);
		@(posedge ref_clk);
		pwm <= 3'h0;
		psel <= 3'h0;
		repeat (4) @(posedge ref_clk);
		#1;
		chk("pwm_off", hs_on, 3'h0);
		cmd(2'h2, 4'h3, 1'b1);
		settle;
		chk("static", hs_on, 3'h7);
		$display("pwm tests done");
		@(posedge ref_clk);
		cpe <= 1'b0;
		repeat (6) @(posedge ref_clk);
		#1;
		chk("pump_act", {hs_act, ls_act}, 18'h0);
		chk("pump_on", {hs_on, ls_on}, 6'h0);
		chk("pump_st", hs_st, 18'h0);
		@(posedge ref_clk);
		cpe <= 1'b1;
		repeat (6) @(posedge ref_clk);
		#1;
		chk("pump_re", hs_act, {3{3'h4}});
		@(posedge ref_clk);
		rst <= 1'b1;
		repeat (3) @(posedge ref_clk);
		#1;
		chk("rst_act", {hs_act, ls_act}, 18'h0);
		chk("rst_hst", hs_st, 18'h0);
		chk("rst_lst", ls_st, 18'h0);
		chk("rst_misc", {hs_on, ls_on, busy, ex}, 10'h0);
		@(posedge ref_clk);
		rst <= 1'b0;
		repeat (2) @(posedge ref_clk);
		#1;
		chk("post_act", {hs_act, ls_act}, 18'h0);
		cmd(2'h1, 4'h4, 1'b0);
		settle;
		chk("post_ls", ls_act, {3{3'h4}});
		chk("post_on", ls_on, 3'h7);
		$display("pump and reset tests done");
		test_done;
	end
endmodule // hbs_sequencer_tb

// *** logic/hbs_regs.vh ***
// Constants of the half-bridge static gate sequencer.
`ifndef HBS_REGS_VH
`define HBS_REGS_VH

// =============================================================
// Bridge mode codes
`define HBS_MODE_PASSIVE   2'h0
`define HBS_MODE_LS_ON     2'h1
`define HBS_MODE_HS_ON     2'h2
`define HBS_MODE_ACT_OFF   2'h3

// =============================================================
// Gate drive action codes per gate output
`define HBS_ACT_PASSIVE    3'h0
`define HBS_ACT_CHARGE     3'h1
`define HBS_ACT_DISCHARGE  3'h2
`define HBS_ACT_HARD_OFF   3'h3
`define HBS_ACT_HOLD_ON    3'h4
`define HBS_ACT_HOLD_OFF   3'h5

// =============================================================
// Current steps
`define HBS_STEP_HOLD_LO   6'h0F
`define HBS_STEP_HOLD_HI   6'h14
`define HBS_STEP_HARD_OFF  6'h3F

// =============================================================
// Timing
`define HBS_CLK_MHZ        100
`define HBS_EXEC_MAX_NS    3000
`define HBS_EXEC_MAX_CYC   ((`HBS_EXEC_MAX_NS * `HBS_CLK_MHZ) / 1000)
`define HBS_TIME_W         16

`endif

// *** logic/hbs_sequencer.v ***
// Static gate sequencer for three half-bridges.
`timescale 1ns/10ps
`include "hbs_regs.vh"

module hbs_sequencer #(
	parameter integer NB = 3,
	parameter integer TW = `HBS_TIME_W
) (
	// Clock and reset
	input  wire            ref_clk_in,
	input  wire            reset_in,
	// Command path
	input  wire            cs_n_in,
	input  wire            charge_pump_enable_in,
	input  wire [2*NB-1:0] bridge_mode_sel_in,
	input  wire [NB-1:0]   bridge_pwm_select_in,
	input  wire [4*NB-1:0] static_drive_current_code_in,
	input  wire            hold_current_select_in,
	input  wire [NB-1:0]   pwm_in,
	// Phase durations in cycles, per bridge
	input  wire [TW*NB-1:0] guard_time_in,
	input  wire [TW*NB-1:0] blank_time_in,
	input  wire [TW*NB-1:0] drain_source_filter_time_in,
	// Gate drive
	output reg  [NB-1:0]   high_side_gate_on_out,
	output reg  [NB-1:0]   low_side_gate_on_out,
	output reg  [3*NB-1:0] high_side_gate_act_out,
	output reg  [3*NB-1:0] low_side_gate_act_out,
	output reg  [6*NB-1:0] high_side_gate_step_out,
	output reg  [6*NB-1:0] low_side_gate_step_out,
	output reg  [NB-1:0]   bridge_busy_out,
	output reg             cmd_exec_out
);

	// =============================================================
	// Phase states
	localparam [3:0] ST_IDLE  = 4'h1;
	localparam [3:0] ST_GUARD = 4'h2;
	localparam [3:0] ST_CHG   = 4'h4;
	localparam [3:0] ST_HOLD  = 4'h8;

	// =============================================================
	// Helpers
	function [5:0] code_step;
		input [3:0] code;
		begin
			code_step = {code, 2'b00};
		end
	endfunction

	// =============================================================
	// Chip-select, pump-enable and PWM synchronisers; chip-select rising edge
	reg cs_s1_r;
	reg cs_s2_r;
	reg cs_s3_r;
	reg cp_s1_r;
	reg cp_s2_r;
	reg [NB-1:0] pwm_s1_r;
	reg [NB-1:0] pwm_s2_r;
	wire cs_rise = cs_s2_r & ~cs_s3_r;

	always @(posedge ref_clk_in) begin
		if (reset_in) begin
			cs_s1_r  <= 1'b1;
			cs_s2_r  <= 1'b1;
			cs_s3_r  <= 1'b1;
			cp_s1_r  <= 1'b0;
			cp_s2_r  <= 1'b0;
			pwm_s1_r <= {NB{1'b0}};
			pwm_s2_r <= {NB{1'b0}};
		end else begin
			cs_s1_r  <= cs_n_in;
			cs_s2_r  <= cs_s1_r;
			cs_s3_r  <= cs_s2_r;
			cp_s1_r  <= charge_pump_enable_in;
			cp_s2_r  <= cp_s1_r;
			pwm_s1_r <= pwm_in;
			pwm_s2_r <= pwm_s1_r;
		end
	end

	// =============================================================
	// Per-bridge sequencers
	reg [2*NB-1:0] mode_s1_r;
	reg [2*NB-1:0] mode_s2_r;
	reg [NB-1:0]   psel_s1_r;
	reg [NB-1:0]   psel_s2_r;
	reg [4*NB-1:0] code_s1_r;
	reg [4*NB-1:0] code_s2_r;
	reg            hsel_s1_r;
	reg            hsel_s2_r;
	reg [NB-1:0]   pwm_sel_r;
	reg [4*NB-1:0] code_r;
	reg            hold_sel_r;
	reg [NB-1:0]   exec_r;

	// Command fields cross through two stages, in step with the chip-select path.
	always @(posedge ref_clk_in) begin
		if (reset_in) begin
			mode_s1_r <= {2*NB{1'b0}};
			mode_s2_r <= {2*NB{1'b0}};
			psel_s1_r <= {NB{1'b0}};
			psel_s2_r <= {NB{1'b0}};
			code_s1_r <= {4*NB{1'b0}};
			code_s2_r <= {4*NB{1'b0}};
			hsel_s1_r <= 1'b0;
			hsel_s2_r <= 1'b0;
		end else begin
			mode_s1_r <= bridge_mode_sel_in;
			mode_s2_r <= mode_s1_r;
			psel_s1_r <= bridge_pwm_select_in;
			psel_s2_r <= psel_s1_r;
			code_s1_r <= static_drive_current_code_in;
			code_s2_r <= code_s1_r;
			hsel_s1_r <= hold_current_select_in;
			hsel_s2_r <= hsel_s1_r;
		end
	end

	// Command fields are latched on the synchronised chip-select edge.
	always @(posedge ref_clk_in) begin
		if (reset_in) begin
			pwm_sel_r  <= {NB{1'b0}};
			code_r     <= {4*NB{1'b0}};
			hold_sel_r <= 1'b0;
		end else if (cs_rise) begin
			pwm_sel_r  <= psel_s2_r;
			code_r     <= code_s2_r;
			hold_sel_r <= hsel_s2_r;
		end
	end

	wire [5:0] hold_step = hold_sel_r ? `HBS_STEP_HOLD_HI : `HBS_STEP_HOLD_LO;

	genvar b;
	generate
		for (b = 0; b < NB; b = b + 1) begin : g_br
			reg [3:0]    st_r;
			reg [TW:0]   cnt_r;
			reg [1:0]    cur_r;
			wire [1:0]   new_mode = mode_s2_r[2*b+1:2*b];
			wire [TW-1:0] t_guard = guard_time_in[TW*b+TW-1:TW*b];
			wire [TW:0]  t_chg = {1'b0, blank_time_in[TW*b+TW-1:TW*b]}
				+ {1'b0, drain_source_filter_time_in[TW*b+TW-1:TW*b]};
			wire [5:0]   cstep = code_step(code_r[4*b+3:4*b]);
			wire         turn_on = (new_mode == `HBS_MODE_LS_ON) |
				(new_mode == `HBS_MODE_HS_ON);
			wire         was_on = (cur_r == `HBS_MODE_LS_ON) |
				(cur_r == `HBS_MODE_HS_ON);
			reg [2:0]    hs_act;
			reg [2:0]    ls_act;
			reg [5:0]    hs_stp;
			reg [5:0]    ls_stp;
			reg          on_act;
			reg [2:0]    off_act;
			reg [5:0]    on_stp;
			reg [5:0]    off_stp;

			// A new command restarts the sequence from the present gate state.
			always @(posedge ref_clk_in) begin
				if (reset_in) begin
					st_r  <= ST_IDLE;
					cnt_r <= {(TW+1){1'b0}};
					cur_r <= `HBS_MODE_PASSIVE;
				end else if (cs_rise) begin
					cur_r <= new_mode;
					if (new_mode == `HBS_MODE_PASSIVE && cur_r == `HBS_MODE_PASSIVE) begin
						st_r <= ST_IDLE;
					end else if (turn_on && (!was_on || cur_r == new_mode)) begin
						st_r  <= ST_CHG;
						cnt_r <= t_chg;
					end else begin
						st_r  <= ST_GUARD;
						cnt_r <= {1'b0, t_guard};
					end
				end else begin
					case (st_r)
						ST_IDLE: begin
							st_r <= ST_IDLE;
						end
						ST_GUARD: begin
							if (cnt_r <= 1) begin
								st_r  <= (cur_r == `HBS_MODE_LS_ON ||
									cur_r == `HBS_MODE_HS_ON) ? ST_CHG : ST_HOLD;
								cnt_r <= t_chg;
							end else begin
								cnt_r <= cnt_r - 1'b1;
							end
						end
						ST_CHG: begin
							if (cnt_r <= 1) begin
								st_r <= ST_HOLD;
							end else begin
								cnt_r <= cnt_r - 1'b1;
							end
						end
						ST_HOLD: begin
							st_r <= ST_HOLD;
						end
						default: begin
							st_r <= ST_IDLE;
						end
					endcase
				end
			end

			// Drive the gate turning on and the opposite gate; swapped for low-side.
			always @* begin
				on_act  = 1'b0;
				off_act = `HBS_ACT_HOLD_OFF;
				on_stp  = hold_step;
				off_stp = hold_step;
				hs_act  = `HBS_ACT_PASSIVE;
				ls_act  = `HBS_ACT_PASSIVE;
				hs_stp  = 6'h00;
				ls_stp  = 6'h00;
				case (st_r)
					ST_GUARD: begin
						off_act = `HBS_ACT_DISCHARGE;
						off_stp = cstep;
					end
					ST_CHG: begin
						on_act  = 1'b1;
						off_act = `HBS_ACT_HARD_OFF;
						on_stp  = cstep;
						off_stp = `HBS_STEP_HARD_OFF;
					end
					default: begin
						on_act  = 1'b0;
					end
				endcase
				if (!cp_s2_r || st_r == ST_IDLE ||
					(cur_r == `HBS_MODE_PASSIVE && st_r == ST_HOLD)) begin
					hs_act = `HBS_ACT_PASSIVE;
					ls_act = `HBS_ACT_PASSIVE;
				end else if (cur_r == `HBS_MODE_HS_ON) begin
					hs_act = (st_r == ST_GUARD) ? off_act :
						(on_act ? `HBS_ACT_CHARGE : `HBS_ACT_HOLD_ON);
					hs_stp = (st_r == ST_GUARD) ? off_stp : on_stp;
					ls_act = off_act;
					ls_stp = off_stp;
				end else if (cur_r == `HBS_MODE_LS_ON) begin
					ls_act = (st_r == ST_GUARD) ? off_act :
						(on_act ? `HBS_ACT_CHARGE : `HBS_ACT_HOLD_ON);
					ls_stp = (st_r == ST_GUARD) ? off_stp : on_stp;
					hs_act = off_act;
					hs_stp = off_stp;
				end else begin
					hs_act = off_act;
					ls_act = off_act;
					hs_stp = off_stp;
					ls_stp = off_stp;
				end
			end

			// Registered gate outputs; PWM-selected bridges drive the gate of their on mode from the PWM input while the pump is enabled.
			always @(posedge ref_clk_in) begin
				if (reset_in) begin
					high_side_gate_on_out[b]         <= 1'b0;
					low_side_gate_on_out[b]          <= 1'b0;
					high_side_gate_act_out[3*b+2:3*b] <= `HBS_ACT_PASSIVE;
					low_side_gate_act_out[3*b+2:3*b]  <= `HBS_ACT_PASSIVE;
					high_side_gate_step_out[6*b+5:6*b] <= 6'h00;
					low_side_gate_step_out[6*b+5:6*b]  <= 6'h00;
					bridge_busy_out[b]               <= 1'b0;
					exec_r[b]                        <= 1'b0;
				end else begin
					exec_r[b] <= cs_rise;
					bridge_busy_out[b] <= (st_r == ST_GUARD) | (st_r == ST_CHG);
					high_side_gate_act_out[3*b+2:3*b] <= hs_act;
					low_side_gate_act_out[3*b+2:3*b]  <= ls_act;
					high_side_gate_step_out[6*b+5:6*b] <= hs_stp;
					low_side_gate_step_out[6*b+5:6*b]  <= ls_stp;
					if (pwm_sel_r[b] && cp_s2_r) begin
						high_side_gate_on_out[b] <= (cur_r == `HBS_MODE_HS_ON) & pwm_s2_r[b];
						low_side_gate_on_out[b]  <= (cur_r == `HBS_MODE_LS_ON) & pwm_s2_r[b];
					end else begin
						high_side_gate_on_out[b] <= (hs_act == `HBS_ACT_CHARGE) |
							(hs_act == `HBS_ACT_HOLD_ON);
						low_side_gate_on_out[b]  <= (ls_act == `HBS_ACT_CHARGE) |
							(ls_act == `HBS_ACT_HOLD_ON);
					end
				end
			end
		end
	endgenerate

	always @(posedge ref_clk_in) begin
		if (reset_in) begin
			cmd_exec_out <= 1'b0;
		end else begin
			cmd_exec_out <= |exec_r;
		end
	end

endmodule // hbs_sequencer
